// file: verilog/bsc_pkg.sv
// Purpose: constants and types for the speed/commutation config bank
// Assumes: 20 MHz system clock, 24-bit serial register frames
// Notes: angles are in units of 1/8 electrical degree
package bsc_pkg;
    localparam int CLK_HZ = 20_000_000;
    // serial frame: write flag, 15-bit address, 8-bit data, msb first
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] ADDR_LAST = 5'h0F;
    // register offsets
    localparam logic [14:0] A_DUTY_LO = 15'h000D;
    localparam logic [14:0] A_DUTY_HI = 15'h000E;
    localparam logic [14:0] A_TAGL_LO = 15'h000F;
    localparam logic [14:0] A_TAGL_HI = 15'h0010;
    localparam logic [14:0] A_TAGH_LO = 15'h0011;
    localparam logic [14:0] A_TAGH_HI = 15'h0012;
    localparam logic [14:0] A_RECALCULATION_TRIGGER = 15'h0013;
    localparam logic [14:0] A_WINSEL = 15'h0015;
    localparam logic [14:0] A_ANG_SIX = 15'h0016;
    localparam logic [14:0] A_ANG_ONE = 15'h0019;
    localparam logic [14:0] A_RBRAKE = 15'h001A;
    localparam logic [14:0] A_CONF0 = 15'h0100;
    localparam logic [14:0] A_CONF1 = 15'h0101;
    localparam logic [14:0] A_CONF2 = 15'h0102;
    localparam logic [14:0] A_CONF3 = 15'h0103;
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions in config 0..2
    localparam int B_DIR = 7;
    localparam int B_FREE = 6;
    localparam int B_LOOP = 5;
    localparam int B_FRANGE = 4;
    localparam int B_SPEED_LOOP_PERIOD_BIT = 1;
    localparam int B_INSEL = 0;
    localparam int B_FAST = 1;
    localparam int B_POL = 0;
    localparam int B_STABLE = 7;
    // speed limit decode
    localparam logic [14:0] RPM_CLAMP_CODE = 15'h4E20;
    localparam logic [15:0] RPM_MAX = 16'h9C40;
    // angle decode, eighths of a degree
    localparam logic [9:0] EN_LO_BASE = 10'h078;
    localparam logic [9:0] EN_LO_STEP = 10'h01E;
    localparam logic [9:0] EN_HI_BASE = 10'h14A;
    localparam logic [9:0] EN_HI_STEP = 10'h00F;
    localparam logic [9:0] MASK_STEP = 10'h00F;
    // fallback duties on a 10-bit scale
    localparam logic [9:0] DUTY_Q1 = 10'h100;
    localparam logic [9:0] DUTY_Q2 = 10'h200;
    localparam logic [9:0] DUTY_Q3 = 10'h300;
    localparam logic [9:0] DUTY_FULL = 10'h3FF;
    // current limit mask step
    localparam int CL_STEP_NS = 200;
    localparam int CL_STEP_CYC = (CL_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;
    // input pwm frequency window
    localparam longint PWM_FMIN_MHZ = 5300;
    localparam int PWM_FMAX_LO_HZ = 1000;
    localparam int PWM_FMAX_HI_HZ = 18500;
    localparam int PWM_PER_MAX_CYC = int'((longint'(CLK_HZ) * 1000)
        / PWM_FMIN_MHZ);
    localparam int PWM_PER_MIN_LO_CYC = (CLK_HZ + PWM_FMAX_LO_HZ - 1)
        / PWM_FMAX_LO_HZ;
    localparam int PWM_PER_MIN_HI_CYC = (CLK_HZ + PWM_FMAX_HI_HZ - 1)
        / PWM_FMAX_HI_HZ;
    localparam int PWM_CW = 22;
    localparam logic [2:0] STEPS_PER_CYCLE = 3'h5;
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_CMD = 2'b01,
        SP_DATA = 2'b10,
        SP_DONE = 2'b11
    } bsc_spi_t;
endpackage : bsc_pkg

// file: verilog/bsc_config_bank.sv
// Purpose: speed/commutation configuration bank with its decoders
// Assumes: pins synchronous to clk_sys; serial port sampled by clk_sys
// Notes: state lives in one packed struct registered once
`timescale 1ns/1ps
module bsc_config_bank
    import bsc_pkg::*;
#(
    parameter int PWM_PER_MAX = PWM_PER_MAX_CYC,
    parameter int PWM_PER_MIN_LO = PWM_PER_MIN_LO_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic high_voltage_pwm_pin,
    input wire logic low_voltage_pwm_pin,
    input wire logic enable_in,
    input wire logic duty_decoded,
    input wire logic reverse_detected,
    input wire logic rotation_stopped,
    input wire logic elec_step,
    input wire logic bemf_detect,
    input wire logic cl_comp,
    output logic direction_bit,
    output logic free_run_start_bit,
    output logic loop_mode_bit,
    output logic [15:0] lower_rpm,
    output logic [15:0] upper_rpm,
    output logic [7:0] duty_lower_limit,
    output logic [7:0] duty_upper_limit,
    output logic full_duty_fixed,
    output logic [2:0] window_count,
    output logic [9:0] energize_angle,
    output logic [9:0] mask_angle,
    output logic brake_all_low,
    output logic fast_start_active,
    output logic pwm_level,
    output logic pwm_freq_ok,
    output logic full_off,
    output logic [9:0] full_duty,
    output logic zero_off,
    output logic [9:0] zero_duty,
    output logic speed_calc_tick,
    output logic [23:0] speed_period,
    output logic [23:0] lead_interval,
    output logic fg_out,
    output logic cl_event
);
    typedef struct packed {
        bsc_spi_t sp;
        logic [4:0] cnt;
        logic [23:0] sh;
        logic [7:0] tx;
        logic sclk_q;
        logic miso;
        logic [7:0] duty_l;
        logic [7:0] duty_h;
        logic [14:0] tag_l;
        logic [14:0] tag_h;
        logic recalculation_trigger;
        logic [1:0] win;
        logic [3:0][7:0] ang;
        logic rbrake;
        logic [7:0] cf0;
        logic [7:0] cf1;
        logic [7:0] cf2;
        logic [7:0] cf3;
        logic lat_mode;
        logic [7:0] lat_dl;
        logic [7:0] lat_dh;
        logic [14:0] lat_tl;
        logic [14:0] lat_th;
        logic [15:0] lo_rpm;
        logic [15:0] up_rpm;
        logic top_fixed;
        logic [2:0] win_cnt;
        logic [9:0] en_ang;
        logic [9:0] mk_ang;
        logic brake;
        logic fast;
        logic pwm_q;
        logic [PWM_CW-1:0] pwm_cnt;
        logic pwm_ok;
        logic [10:0] fb_full;
        logic [10:0] fb_zero;
        logic [2:0] m6;
        logic [23:0] per360;
        logic [23:0] sp_per;
        logic sp_tick;
        logic [23:0] iv;
        logic [23:0] lead;
        logic fg;
        logic [2:0] fgc;
        logic [6:0] clm;
        logic cl_evt;
    } bsc_state_t;

    bsc_state_t s_reg;
    bsc_state_t s_next;
    logic set_recalculation_trigger;
    logic [PWM_CW-1:0] per_max;

    assign per_max = PWM_CW'(PWM_PER_MAX);

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic [15:0] rpm_of(input logic [14:0] code);
        rpm_of = (code >= RPM_CLAMP_CODE) ? RPM_MAX : {code, 1'b0};
    endfunction : rpm_of

    // {off, duty}; limits above full scale saturate
    function automatic logic [10:0] fallback(input logic [2:0] code,
        input logic [14:0] tl, input logic [14:0] th);
        logic [14:0] t;
        t = (code == 3'h6) ? th : tl;
        case (code)
            3'h1: fallback = {1'b0, DUTY_Q1};
            3'h2: fallback = {1'b0, DUTY_Q2};
            3'h3: fallback = {1'b0, DUTY_Q3};
            3'h4: fallback = {1'b0, DUTY_FULL};
            3'h5, 3'h6: begin
                fallback = {1'b0, (|t[14:10]) ? DUTY_FULL : t[9:0]};
            end
            default: fallback = {1'b1, 10'h000};
        endcase
    endfunction : fallback

    // reserved bits read as zero
    function automatic logic [7:0] read_reg(input bsc_state_t s,
        input logic [14:0] a);
        if (a == A_DUTY_LO) read_reg = s.duty_l;
        else if (a == A_DUTY_HI) read_reg = s.duty_h;
        else if (a == A_TAGL_LO) read_reg = s.tag_l[7:0];
        else if (a == A_TAGL_HI) read_reg = {1'b0, s.tag_l[14:8]};
        else if (a == A_TAGH_LO) read_reg = s.tag_h[7:0];
        else if (a == A_TAGH_HI) read_reg = {1'b0, s.tag_h[14:8]};
        else if (a == A_RECALCULATION_TRIGGER) read_reg = {7'h00, s.recalculation_trigger};
        else if (a == A_WINSEL) read_reg = {6'h00, s.win};
        else if (a >= A_ANG_SIX && a <= A_ANG_ONE) begin
            read_reg = s.ang[2'(a - A_ANG_SIX)];
        end
        else if (a == A_RBRAKE) read_reg = {7'h00, s.rbrake};
        else if (a == A_CONF0) read_reg = s.cf0;
        else if (a == A_CONF1) read_reg = s.cf1;
        else if (a == A_CONF2) read_reg = s.cf2;
        else if (a == A_CONF3) read_reg = s.cf3;
        else read_reg = 8'h00;
    endfunction : read_reg

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic rise;
        logic fall;
        logic [23:0] w;
        logic [7:0] d;
        logic [14:0] a;
        logic [7:0] pair;
        logic lvl;
        logic stable6;
        logic [2:0] c;
        logic [PWM_CW-1:0] per_min;
        rise = spi_sclk && !s_reg.sclk_q;
        fall = !spi_sclk && s_reg.sclk_q;
        pair = 8'h00;
        lvl = 1'b0;
        stable6 = 1'b0;
        c = 3'h0;
        per_min = '0;
        w = {s_reg.sh[22:0], spi_mosi};
        d = w[7:0];
        a = w[22:8];
        s_next = s_reg;
        set_recalculation_trigger = 1'b0;
        s_next.sclk_q = spi_sclk;
        // serial port: frame shifts on rising sclk, miso moves on falling
        if (spi_cs_n) begin
            s_next.sp = SP_IDLE;
            s_next.cnt = 5'h00;
        end else begin
            case (s_reg.sp)
                SP_IDLE: s_next.sp = SP_CMD;
                SP_CMD: begin
                    if (rise) begin
                        s_next.sh = w;
                        s_next.cnt = s_reg.cnt + 5'h01;
                        if (s_reg.cnt == ADDR_LAST) begin
                            s_next.tx = read_reg(s_reg, w[14:0]);
                            s_next.sp = SP_DATA;
                        end
                    end
                end
                SP_DATA: begin
                    if (fall) begin
                        s_next.miso = s_reg.tx[7];
                        s_next.tx = {s_reg.tx[6:0], 1'b0};
                    end
                    if (rise) begin
                        s_next.sh = w;
                        s_next.cnt = s_reg.cnt + 5'h01;
                        if (s_reg.cnt == FRAME_LAST) begin
                            s_next.sp = SP_DONE;
                        end
                    end
                end
                default: s_next.sp = SP_DONE;
            endcase
        end
        // target calculator latch; trigger self-clears next cycle
        if (s_reg.recalculation_trigger) begin
            s_next.lat_mode = s_reg.cf0[B_LOOP];
            s_next.lat_dl = s_reg.duty_l;
            s_next.lat_dh = s_reg.duty_h;
            s_next.lat_tl = s_reg.tag_l;
            s_next.lat_th = s_reg.tag_h;
            s_next.recalculation_trigger = 1'b0;
        end
        // register writes; a new trigger beats the self clear
        if (s_reg.sp == SP_DATA && rise && s_reg.cnt == FRAME_LAST
            && w[23]) begin
            if (a == A_DUTY_LO) s_next.duty_l = d;
            else if (a == A_DUTY_HI) s_next.duty_h = d;
            else if (a == A_TAGL_LO) s_next.tag_l[7:0] = d;
            else if (a == A_TAGL_HI) s_next.tag_l[14:8] = d[6:0];
            else if (a == A_TAGH_LO) s_next.tag_h[7:0] = d;
            else if (a == A_TAGH_HI) s_next.tag_h[14:8] = d[6:0];
            else if (a == A_RECALCULATION_TRIGGER) begin
                set_recalculation_trigger = d[0];
                if (d[0]) s_next.recalculation_trigger = 1'b1;
            end
            else if (a == A_WINSEL) s_next.win = d[1:0];
            else if (a >= A_ANG_SIX && a <= A_ANG_ONE) begin
                s_next.ang[2'(a - A_ANG_SIX)] = d;
            end
            else if (a == A_RBRAKE) s_next.rbrake = d[0];
            else if (a == A_CONF0) s_next.cf0 = d;
            else if (a == A_CONF1) s_next.cf1 = d;
            else if (a == A_CONF2) s_next.cf2 = d;
            else if (a == A_CONF3) s_next.cf3 = d;
        end
        // speed limits from latched values, open loop ignores them
        s_next.lo_rpm = s_reg.lat_mode ? 16'h0000 : rpm_of(s_reg.lat_tl);
        s_next.up_rpm = s_reg.lat_mode ? 16'h0000 : rpm_of(s_reg.lat_th);
        s_next.top_fixed = s_reg.lat_mode;
        // window count and its angle pair
        case (s_reg.win)
            2'b00: s_next.win_cnt = 3'h6;
            2'b01: s_next.win_cnt = 3'h3;
            2'b10: s_next.win_cnt = 3'h2;
            default: s_next.win_cnt = 3'h1;
        endcase
        pair = s_reg.ang[s_reg.win];
        if (pair[7:4] < 4'h8) begin
            s_next.en_ang = EN_LO_BASE + EN_LO_STEP * 10'(pair[7:4]);
        end else begin
            s_next.en_ang = EN_HI_BASE
                + EN_HI_STEP * 10'(pair[7:4] - 4'h7);
        end
        s_next.mk_ang = MASK_STEP * (10'(pair[3:0]) + 10'h001);
        // brake holds until stop; dropping the enable releases it
        s_next.brake = s_reg.rbrake && !rotation_stopped
            && (s_reg.brake || reverse_detected);
        s_next.fast = s_reg.cf1[B_FAST] && enable_in && !duty_decoded;
        // fallback actions for the two input extremes
        s_next.fb_full = fallback(s_reg.cf1[7:5], s_reg.lat_tl,
            s_reg.lat_th);
        s_next.fb_zero = fallback(s_reg.cf1[4:2], s_reg.lat_tl,
            s_reg.lat_th);
        // input pwm: pick pin, apply polarity, check period window
        lvl = s_reg.cf0[B_INSEL] ? low_voltage_pwm_pin
            : high_voltage_pwm_pin;
        lvl = lvl ^ s_reg.cf1[B_POL];
        s_next.pwm_q = lvl;
        per_min = s_reg.cf0[B_FRANGE] ? PWM_CW'(PWM_PER_MIN_HI_CYC)
            : PWM_CW'(PWM_PER_MIN_LO);
        if (lvl && !s_reg.pwm_q) begin
            s_next.pwm_ok = s_reg.pwm_cnt >= per_min
                && s_reg.pwm_cnt <= per_max;
            s_next.pwm_cnt = PWM_CW'(1);
        end else if (s_reg.pwm_cnt <= per_max) begin
            s_next.pwm_cnt = s_reg.pwm_cnt + PWM_CW'(1);
            // drop ok as the count passes max, not one cycle late
            if (s_reg.pwm_cnt == per_max) s_next.pwm_ok = 1'b0;
        end else begin
            s_next.pwm_ok = 1'b0;
        end
        // speed loop and lead-angle sampling on 60 degree steps
        stable6 = s_reg.cf2[B_STABLE] && s_reg.win == 2'b00;
        s_next.sp_tick = 1'b0;
        if (s_reg.per360 != 24'hFF_FFFF) begin
            s_next.per360 = s_reg.per360 + 24'h00_0001;
        end
        if (s_reg.iv != 24'hFF_FFFF) s_next.iv = s_reg.iv + 24'h00_0001;
        if (elec_step) begin
            s_next.m6 = (s_reg.m6 == STEPS_PER_CYCLE) ? 3'h0
                : s_reg.m6 + 3'h1;
            if (s_reg.m6 == STEPS_PER_CYCLE) begin
                s_next.sp_per = s_reg.per360;
                s_next.per360 = 24'h00_0001;
            end
            s_next.sp_tick = s_reg.cf0[B_SPEED_LOOP_PERIOD_BIT] ? s_reg.m6[0]
                : (s_reg.m6 == STEPS_PER_CYCLE);
            if (!stable6 || s_reg.m6[0]) begin
                s_next.lead = stable6 ? {1'b0, s_reg.iv[23:1]}
                    : s_reg.iv;
                s_next.iv = 24'h00_0001;
            end
        end
        // fg divider over a six-detection cycle
        if (bemf_detect) begin
            c = (s_reg.fgc == STEPS_PER_CYCLE) ? 3'h0 : s_reg.fgc + 3'h1;
            s_next.fgc = c;
            case (s_reg.cf2[6:5])
                2'h0: s_next.fg = !s_reg.fg;
                2'h1: s_next.fg = s_reg.fg ^ !c[0];
                2'h2: s_next.fg = !(c == 3'h2 || c == 3'h5);
                default: begin
                    s_next.fg = s_reg.fg ^ (c == 3'h0 || c == 3'h3);
                end
            endcase
        end
        // current limit: blank further events for the mask time
        s_next.cl_evt = 1'b0;
        if (s_reg.clm != 7'h00) begin
            s_next.clm = s_reg.clm - 7'h01;
        end else if (cl_comp) begin
            s_next.cl_evt = 1'b1;
            s_next.clm = 7'(CL_STEP_CYC) * (7'(s_reg.cf3[7:4]) + 7'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register, everything resets to zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign spi_miso = s_reg.miso;
    assign direction_bit = s_reg.cf0[B_DIR];
    assign free_run_start_bit = s_reg.cf0[B_FREE];
    assign loop_mode_bit = s_reg.lat_mode;
    assign lower_rpm = s_reg.lo_rpm;
    assign upper_rpm = s_reg.up_rpm;
    assign duty_lower_limit = s_reg.lat_dl;
    assign duty_upper_limit = s_reg.lat_dh;
    assign full_duty_fixed = s_reg.top_fixed;
    assign window_count = s_reg.win_cnt;
    assign energize_angle = s_reg.en_ang;
    assign mask_angle = s_reg.mk_ang;
    assign brake_all_low = s_reg.brake;
    assign fast_start_active = s_reg.fast;
    assign pwm_level = s_reg.pwm_q;
    assign pwm_freq_ok = s_reg.pwm_ok;
    assign full_off = s_reg.fb_full[10];
    assign full_duty = s_reg.fb_full[9:0];
    assign zero_off = s_reg.fb_zero[10];
    assign zero_duty = s_reg.fb_zero[9:0];
    assign speed_calc_tick = s_reg.sp_tick;
    assign speed_period = s_reg.sp_per;
    assign lead_interval = s_reg.lead;
    assign fg_out = s_reg.fg;
    assign cl_event = s_reg.cl_evt;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_recalculation_trigger_armed;
        s_reg.recalculation_trigger ##0 !set_recalculation_trigger;
    endsequence

    sequence s_recalculation_trigger_done;
        !s_reg.recalculation_trigger ##1 s_reg.lo_rpm == s_next.lo_rpm;
    endsequence

    a_recalculation_trigger_clear: assert property (s_recalculation_trigger_armed |=> s_recalculation_trigger_done)
        else $error("recalculation_trigger trigger did not self clear");
    a_recalculation_trigger_load: assert property (s_reg.recalculation_trigger |=>
        s_reg.lat_th == $past(s_reg.tag_h)
        && s_reg.lat_mode == $past(s_reg.cf0[B_LOOP]))
        else $error("limits not latched on recalculation_trigger");
    a_lower_rpm: assert property (!s_reg.lat_mode
        && s_reg.lat_tl < RPM_CLAMP_CODE && !s_reg.recalculation_trigger
        |=> s_reg.lo_rpm == {$past(s_reg.lat_tl), 1'b0})
        else $error("lower rpm not twice the code");
    a_upper_clamp: assert property (!s_reg.lat_mode
        && s_reg.lat_th >= RPM_CLAMP_CODE |=> s_reg.up_rpm == RPM_MAX)
        else $error("upper rpm not clamped");
    a_open_upper: assert property (s_reg.lat_mode
        |=> s_reg.up_rpm == 16'h0000 && s_reg.top_fixed)
        else $error("open loop upper limit not ignored");
    a_window_count: assert property (s_reg.win == 2'b01
        |=> s_reg.win_cnt == 3'h3 || $past(s_next.win) != 2'b01)
        else $error("three-window code decoded wrongly");
    a_mask_angle: assert property (s_reg.win == 2'b11
        && s_reg.ang[3][3:0] == 4'hF ##1 $stable(s_reg.ang)
        |-> s_reg.mk_ang == 10'h0F0)
        else $error("mask angle wrong");
    a_brake_off: assert property (!s_reg.rbrake |=> !s_reg.brake)
        else $error("brake without enable");
    a_brake_hold: assert property (s_reg.brake && s_reg.rbrake
        && !rotation_stopped |=> s_reg.brake)
        else $error("brake released before stop");
    a_fg_toggle: assert property (s_reg.cf2[6:5] == 2'h0
        && bemf_detect |=> s_reg.fg != $past(s_reg.fg))
        else $error("fg did not toggle on detection");
    a_cl_blank: assert property (s_reg.cl_evt
        |=> (!s_reg.cl_evt) [*4])
        else $error("current limit event inside mask");
    a_pwm_timeout: assert property (s_reg.pwm_cnt > per_max
        |-> !s_reg.pwm_ok)
        else $error("slow pwm reported valid");
endmodule : bsc_config_bank

// file: bench/bsc_motor_model.sv
// Purpose: motor side model for the config bank bench
// Assumes: clocked by clk_sys, reverse spin on request
// Notes: a short brake halts the rotor after a coast time
`timescale 1ns/1ps
module bsc_motor_model (
    input wire logic clk_sys,
    input wire logic rev_cmd,
    input wire logic brake_all_low,
    output logic elec_step = 1'b0,
    output logic bemf_detect = 1'b0,
    output logic reverse_detected = 1'b0,
    output logic rotation_stopped = 1'b0,
    output logic cl_comp = 1'b0
);
    logic [7:0] tick = 8'h00;
    logic [4:0] coast = 5'h00;
    // rotor events every 64 clocks, one current spike per 256
    always @(posedge clk_sys) begin
        tick <= tick + 8'h01;
        elec_step <= (tick[5:0] == 6'h3F);
        bemf_detect <= (tick[5:0] == 6'h1F);
        cl_comp <= (tick == 8'h80);
        // rotor only slows while shorted, so no brake means no stop
        coast <= coast + 5'(brake_all_low && coast != 5'h1F);
        rotation_stopped <= (coast == 5'h1F);
        reverse_detected <= rev_cmd && !rotation_stopped;
    end
endmodule : bsc_motor_model

// file: bench/tb_bsc_config_bank.sv
// Purpose: self-checking bench for the config bank
// Assumes: serial port driven at clk_sys falling edges
// Notes: driver queues expectations, a watcher judges them
`timescale 1ns/1ps
module tb_bsc_config_bank;
    import bsc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, spi_cs_n = 1'b1, spi_sclk = 1'b0;
    logic spi_mosi = 1'b0, hv = 1'b0, lv = 1'b0, en = 1'b0, dd = 1'b0;
    logic rev = 1'b0, spi_miso, direction_bit, full_duty_fixed, pwm_level;
    logic brake_all_low, fast_start_active, elec_step, bemf_detect;
    logic reverse_detected, rotation_stopped, cl_comp;
    logic free_run_start_bit, loop_mode_bit, zero_off;
    logic [9:0] full_duty;
    logic [23:0] speed_period, lead_interval;
    logic [15:0] lower_rpm, upper_rpm, obs, exp_q[$];
    logic [9:0] energize_angle, mask_angle;
    logic [2:0] window_count;
    logic [7:0] rq;
    logic [31:0] seed = 32'hc1e3_fbd9;
    int n_fail = 0, num_checks = 0, cyc = 0;
    event seen;
    always #25 clk_sys = ~clk_sys;
    bsc_config_bank i_dut (.clk_sys, .reset, .spi_cs_n, .spi_sclk,
        .spi_mosi, .spi_miso, .high_voltage_pwm_pin(hv),
        .low_voltage_pwm_pin(lv), .enable_in(en), .duty_decoded(dd),
        .reverse_detected, .rotation_stopped, .elec_step, .bemf_detect,
        .cl_comp, .direction_bit, .free_run_start_bit, .loop_mode_bit,
        .lower_rpm, .upper_rpm, .duty_lower_limit(), .duty_upper_limit(),
        .full_duty_fixed, .window_count, .energize_angle, .mask_angle,
        .brake_all_low, .fast_start_active, .pwm_level, .pwm_freq_ok(),
        .full_off(), .full_duty, .zero_off, .zero_duty(),
        .speed_calc_tick(), .speed_period, .lead_interval, .fg_out(),
        .cl_event());
    bsc_motor_model i_motor (.clk_sys, .rev_cmd(rev), .brake_all_low,
        .elec_step, .bemf_detect, .reverse_detected, .rotation_stopped,
        .cl_comp);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // note the expectation, then hand the observed value over
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        exp_q.push_back(e);
        obs = g;
        -> seen;
        @(negedge clk_sys);
    endtask : chk
    always @(seen) begin : watch
        logic [15:0] e;
        e = exp_q.pop_front();
        num_checks++;
        if (e !== obs) begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, obs);
        end
    end
    // one 24-bit frame; sclk levels last two clocks so none is missed
    task automatic xfer(input logic w, input logic [14:0] a,
            input logic [7:0] d);
        logic [23:0] f;
        f = {w, a, d};
        @(negedge clk_sys) spi_cs_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            spi_mosi = f[23 - i];
            spi_sclk = 1'b0;
            repeat (2) @(negedge clk_sys);
            if (i > 15) rq[23 - i] = spi_miso;
            spi_sclk = 1'b1;
            repeat (2) @(negedge clk_sys);
        end
        spi_sclk = 1'b0;
        repeat (2) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        repeat (5) @(negedge clk_sys);
    endtask : xfer
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk({8'h00, rq}, {8'h00, e});
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // cut a hang short well past the expected few thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin : main
        logic [7:0] ang [4];
        int x, e;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        hv = 1'b1;
        // every byte from 11h up and in config 0..3 resets to zero; 14h and 1Bh are holes
        for (int a = 16'h0011; a < 16'h001C; a++) rd(15'(a), REG_RESET);
        for (int a = 16'h0100; a < 16'h0104; a++) rd(15'(a), REG_RESET);
        chk(16'(pwm_level), 16'h0001);
        // rotor model steps every 64 clocks, six steps per cycle
        chk(speed_period[15:0], 16'h0180);
        chk(lead_interval[15:0], 16'h0040);
        // angle pairs: nibble edges 7/8 and 0/F plus random fill
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            ang[i] = (i == 3) ? 8'h8F : ((i == 0) ? 8'h70 : seed[7:0]);
            wr(A_ANG_SIX + 15'(i), ang[i]);
            rd(A_ANG_SIX + 15'(i), ang[i]);
        end
        for (int w = 0; w < 4; w++) begin
            wr(A_WINSEL, 8'(w));
            x = int'(ang[w][7:4]);
            e = x < 8 ? 120 + 30 * x : 330 + 15 * (x - 7);
            chk(16'(window_count), 16'(w == 0 ? 6 : 4 - w));
            chk(16'(energize_angle), 16'(e));
            chk(16'(mask_angle), 16'(15 * (ang[w][3:0] + 1)));
        end
        // limits stay out of use until the trigger, then the upper one clamps
        wr(A_TAGH_LO, 8'h20);
        wr(A_TAGH_HI, 8'h4E);
        wr(A_TAGL_LO, 8'h1F);
        wr(A_TAGL_HI, 8'h4E);
        chk(upper_rpm, 16'h0000);
        wr(A_RECALCULATION_TRIGGER, 8'h01);
        chk(upper_rpm, 16'h9C40);
        chk(lower_rpm, 16'h9C3E);
        rd(A_RECALCULATION_TRIGGER, 8'h00);
        // open loop waits for the trigger; direction acts at once
        wr(A_CONF0, 8'hE0);
        chk(16'(direction_bit), 16'h0001);
        chk(16'(free_run_start_bit), 16'h0001);
        chk(16'(full_duty_fixed), 16'h0000);
        wr(A_RECALCULATION_TRIGGER, 8'h01);
        chk(upper_rpm, 16'h0000);
        chk(16'(full_duty_fixed), 16'h0001);
        chk(16'(loop_mode_bit), 16'h0001);
        // fast start until a duty is decoded; inverted input polarity
        en = 1'b1;
        wr(A_CONF1, 8'h23);
        chk(16'(fast_start_active), 16'h0001);
        chk(16'(pwm_level), 16'h0000);
        chk(16'(full_duty), 16'h0100);
        chk(16'(zero_off), 16'h0001);
        dd = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(16'(fast_start_active), 16'h0000);
        // reverse spin: no brake while disabled, rotor halts once enabled
        rev = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(16'(brake_all_low), 16'h0000);
        wr(A_RBRAKE, 8'h01);
        chk(16'(brake_all_low), 16'h0001);
        for (int i = 0; i < 99 && !rotation_stopped; i++) @(negedge clk_sys);
        chk(16'(rotation_stopped), 16'h0001);
        chk(16'(brake_all_low), 16'h0000);
        #10 wrap_up();
    end
endmodule : tb_bsc_config_bank
